// file: bench/amer_host_model.sv
// host-side register access model for the alert mask block
`timescale 1ns/10ps
module amer_host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] regRdata,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWdata,
    output logic            regWrite,
    output logic            regRead
);
    initial {regAddr, regWdata, regWrite, regRead} = 18'h0;
    // a released address shows its inverse so stale decodes are not hidden
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
        @(posedge mclk) #2;
        regAddr = a;
        regWdata = d;
        regWrite = w;
        regRead = ~w;
        @(posedge mclk);
        q = regRdata;
        #2;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = ~a;
        regWdata = ~d;
    endtask : access
endmodule : amer_host_model

// file: bench/tb_amer_alert_mask.sv
// self-checking bench for alert masking and extended resolution
`timescale 1ns/10ps
module tb_amer_alert_mask;
    logic        mclk, resetn, twelveVoltMode, fourthPinIsTimer, alertOutN, regWrite, regRead;
    logic [7:0]  regAddr, regWdata, regRdata, statusFirst, statusSecond, alertStatusFirst, alertStatusSecond;
    logic [7:0]  q, resultValid;
    logic [79:0] resultIn;
    logic [39:0] r;
    int          miscompares, total_checks, cycles;
    // ------------------------------------------------------------
    // rows: first mask, second mask, first status, second status, twelve-volt mode, expected alert
    // ------------------------------------------------------------
    localparam logic [39:0] ROWS [20] = '{40'hFFFFFFFF11, 40'h0000010000,
        40'h0100010001, 40'h0E000E0001, 40'h7000700001,
        40'h8000800001, 40'h7F00800000, 40'h00FD000200,
        40'h0002000201, 40'h0001000111, 40'h0000000101, 40'h0000000110,
        40'h001C001C01, 40'h0020002001, 40'h00C000C001, 40'h801C801C01,
        40'h0020002001, 40'h0000002000, 40'h00BF004000, 40'h001C801C00};
    amer_alert_mask u_amer_alert_mask (.mclk, .resetn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
        .statusFirst, .statusSecond, .twelveVoltMode, .fourthPinIsTimer, .resultIn, .resultValid,
        .alertStatusFirst, .alertStatusSecond, .alertOutN);
    amer_host_model u_amer_host_model (.mclk, .regRdata, .regAddr, .regWdata, .regWrite, .regRead);
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        u_amer_host_model.access(a, 8'h00, 1'b0, q);
        check(q, e);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_amer_host_model.access(a, d, 1'b1, q);
    endtask : wr
    // channel g upper byte is 0x10*g plus offset, low pair is g mod 4 or its inverse
    task automatic set_res(input logic [7:0] off, input logic inv);
        @(posedge mclk) #2;
        for (int g = 0; g < 8; g++)
            resultIn[g*10+:10] = {8'(8'h10 * g) + off, inv ? ~2'(g) : 2'(g)};
        resultValid = 8'hFF;
        @(posedge mclk) #2;
        resultValid = 8'h00;
    endtask : set_res
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        forever @(posedge mclk)
        begin
            cycles++;
            if (cycles > 4000)
            begin
                miscompares++;
                stop_test();
            end
        end
    end
    initial
    begin
        {resetn, twelveVoltMode, fourthPinIsTimer, statusFirst, statusSecond, resultValid, resultIn} = '0;
        repeat (5) @(posedge mclk);
        #2 resetn = 1'b1;
        for (int a = 8'h74; a < 8'h78; a++)
            rd(8'(a), 8'h00);
        rd(8'h10, 8'h00);
        // the ext reads above froze every channel; reading each upper byte releases it
        for (int a = 8'h20; a < 8'h28; a++)
            rd(8'(a), 8'h00);
        foreach (ROWS[i])
        begin
            r = ROWS[i];
            wr(8'h74, r[39:32]);
            wr(8'h75, r[31:24]);
            {statusFirst, statusSecond, twelveVoltMode, fourthPinIsTimer} = {r[23:8], r[4], 1'(i)};
            repeat (3) @(posedge mclk);
            check({7'h00, alertOutN}, {7'h00, r[0]});
            check(alertStatusFirst, r[23:16]);
            check(alertStatusSecond, r[15:8]);
            rd(8'h75, r[31:24]);
            rd(8'h74, r[39:32]);
        end
        set_res(8'h01, 1'b0);
        rd(8'h76, 8'hE4);
        rd(8'h77, 8'hE4);
        set_res(8'h81, 1'b1);
        rd(8'h76, 8'hE4);
        rd(8'h20, 8'h01);
        set_res(8'h81, 1'b1);
        rd(8'h20, 8'h81);
        rd(8'h21, 8'h11);
        rd(8'h24, 8'h41);
        wr(8'h76, 8'h00);
        rd(8'h76, 8'hE7);
        // mid-run reset must drop the mask and idle the alert
        wr(8'h74, 8'h01);
        wr(8'h75, 8'h02);
        {statusFirst, statusSecond} = 16'h0302;
        @(posedge mclk) #2;
        check({7'h00, alertOutN}, 8'h00);
        resetn = 1'b0;
        @(posedge mclk) #2;
        check({7'h00, alertOutN}, 8'h01);
        resetn = 1'b1;
        repeat (3) @(posedge mclk);
        check({7'h00, alertOutN}, 8'h00);
        rd(8'h74, 8'h00);
        rd(8'h75, 8'h00);
        stop_test();
    end
endmodule : tb_amer_alert_mask

// file: core/amer_alert_mask.sv
// alert masking and extended resolution readout with frozen result set
`timescale 1ns/10ps
module amer_alert_mask #(
    parameter int NCH = amer_pkg::NUM_CHAN,
    parameter int RW  = amer_pkg::RES_WIDTH
) (
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic [7:0]        regAddr,
    input  wire logic [7:0]        regWdata,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [7:0]        regRdata,
    input  wire logic [7:0]        statusFirst,
    input  wire logic [7:0]        statusSecond,
    input  wire logic              twelveVoltMode,
    input  wire logic              fourthPinIsTimer,
    input  wire logic [NCH*RW-1:0] resultIn,
    input  wire logic [NCH-1:0]    resultValid,
    output logic      [7:0]        alertStatusFirst,
    output logic      [7:0]        alertStatusSecond,
    output logic                   alertOutN
);
    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    logic [7:0] maskFirst_r;
    logic [7:0] maskSecond_r;
    logic [RW-1:0] result_r [NCH];
    logic [NCH-1:0] msbPending_r;
    logic [NCH-1:0] msbPending_nxt;
    logic alertN_r;
    logic alertN_nxt;

    wire selMaskFirst  = (regAddr == amer_pkg::MASK_FIRST_ADDR);
    wire selMaskSecond = (regAddr == amer_pkg::MASK_SECOND_ADDR);
    wire selExtVolt    = (regAddr == amer_pkg::EXT_VOLT_ADDR);
    wire selExtMixed   = (regAddr == amer_pkg::EXT_MIXED_ADDR);
    wire [7:0] msbOffset = regAddr - amer_pkg::MSB_BASE_ADDR;
    wire selMsb        = (regAddr >= amer_pkg::MSB_BASE_ADDR) && (msbOffset < 8'(NCH));

    wire [7:0] extVolt;
    wire [7:0] extMixed;
    wire [NCH-1:0] msbReadHit;

    // ----------------------------------------------------------------
    // per-channel result holding
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : gChan
            // frozen channel ignores new conversions until its upper byte is read;
            // the ext read itself blocks too, so a same-cycle update cannot split the pair
            wire extHit = (g < 4) ? (regRead && selExtVolt) : (regRead && selExtMixed);
            wire frozen = msbPending_r[g] | extHit;
            assign msbReadHit[g] = regRead && selMsb && (msbOffset == 8'(g));
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                    result_r[g] <= '0;
                else if (resultValid[g] && !frozen)
                    result_r[g] <= resultIn[g*RW +: RW];
            end
            if (g < 4)
            begin : gLowA
                assign extVolt[2*g +: 2] = result_r[g][1:0];
            end
            else
            begin : gLowB
                assign extMixed[2*(g-4) +: 2] = result_r[g][1:0];
            end
        end
    endgenerate

    // reading an ext register arms freeze on its four channels; upper read releases
    always_comb
    begin
        msbPending_nxt = msbPending_r & ~msbReadHit;
        if (regRead && selExtVolt)
            msbPending_nxt[3:0] = 4'hF;
        if (regRead && selExtMixed)
            msbPending_nxt[7:4] = 4'hF;
    end

    // ----------------------------------------------------------------
    // mask registers and freeze pending flags
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            maskFirst_r  <= amer_pkg::MASK_FIRST_RST;
            maskSecond_r <= amer_pkg::MASK_SECOND_RST;
            msbPending_r <= '0;
        end
        else
        begin
            if (regWrite && selMaskFirst)
                maskFirst_r <= regWdata;
            if (regWrite && selMaskSecond)
                maskSecond_r <= regWdata;
            msbPending_r <= msbPending_nxt;
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [7:0] msbByte = result_r[msbOffset[2:0]][RW-1:2];
    wire [7:0] rdMux = selMaskFirst  ? maskFirst_r  :
                       selMaskSecond ? maskSecond_r :
                       selExtVolt    ? extVolt      :
                       selExtMixed   ? extMixed     :
                       selMsb        ? msbByte      : amer_pkg::READ_UNMAPPED;
    assign regRdata = rdMux;

    // ----------------------------------------------------------------
    // alert gating
    // ----------------------------------------------------------------
    // twelve-volt mask only counts in twelve-volt pin mode; otherwise its status is not a source
    wire twelveGate = twelveVoltMode ? ~maskSecond_r[amer_pkg::TWELVE_VOLT_BIT] : 1'b0;
    // bit 5 covers fan four or timer limit; status producer picks which by pin function
    wire unusedPinFn = fourthPinIsTimer;
    wire [7:0] enFirst  = ~maskFirst_r;
    wire [7:0] enSecond = {~maskSecond_r[7:1], twelveGate};
    wire [7:0] liveFirst  = statusFirst  & enFirst;
    wire [7:0] liveSecond = statusSecond & enSecond;
    // status is passed through untouched so masking never hides it from reads
    assign alertStatusFirst  = statusFirst;
    assign alertStatusSecond = statusSecond;
    assign alertN_nxt = ~(|liveFirst | |liveSecond) | (unusedPinFn & 1'b0);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            alertN_r <= 1'b1;
        else
            alertN_r <= alertN_nxt;
    end
    assign alertOutN = alertN_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    summary_first_a : assert property (@(posedge mclk) disable iff (!resetn)
        (maskFirst_r == 8'h80 && statusFirst == 8'h80 && statusSecond == 8'h00) |=> alertOutN)
        else $error("masked first summary still raised alert");
    low_voltage_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h01 && !maskFirst_r[0] && statusSecond == 8'h00) |=> !alertOutN)
        else $error("unmasked low-voltage event missed");
    mask_first_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusSecond == 8'h00 && (statusFirst & ~maskFirst_r) == 8'h00) |=> alertOutN)
        else $error("masked first-group event raised alert");
    temp_chan_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst[6:4] != 3'h0 && (statusFirst[6:4] & ~maskFirst_r[6:4]) != 3'h0) |=> !alertOutN)
        else $error("unmasked temperature event missed");
    twelve_volt_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusSecond == 8'h01 && statusFirst == 8'h00 && !twelveVoltMode) |=> alertOutN)
        else $error("twelve-volt alert outside its mode");
    fan_diode_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h00 && (statusSecond[7:1] & ~maskSecond_r[7:1]) != 7'h00) |=> !alertOutN)
        else $error("unmasked second-group event missed");
    ext_freeze_a : assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && selExtVolt) |=> msbPending_r[3:0] == 4'hF)
        else $error("ext read did not freeze voltage results");
    hold_frozen_a : assert property (@(posedge mclk) disable iff (!resetn)
        msbPending_r[0] |=> $stable(result_r[0]))
        else $error("frozen result changed");
    release_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h00 && statusSecond == 8'h00) |=> alertOutN)
        else $error("alert held with no condition");

    // ----------------------------------------------------------------
    // checks: first group
    // ----------------------------------------------------------------
    low_volt_masked_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h01 && statusSecond == 8'h00 && maskFirst_r[0])
        |=> alertOutN)
        else $error("masked low-voltage event raised alert");
    core_chan_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h02 && statusSecond == 8'h00 && !maskFirst_r[1])
        |=> !alertOutN)
        else $error("unmasked core event missed");
    supply_chan_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h04 && statusSecond == 8'h00 && !maskFirst_r[2])
        |=> !alertOutN)
        else $error("unmasked supply event missed");
    five_volt_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h08 && statusSecond == 8'h00 && !maskFirst_r[3])
        |=> !alertOutN)
        else $error("unmasked five-volt event missed");
    temp_masked_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusSecond == 8'h00 && statusFirst[7] == 1'b0 && statusFirst[3:0] == 4'h0
            && (statusFirst[6:4] & ~maskFirst_r[6:4]) == 3'h0) |=> alertOutN)
        else $error("masked temperature event raised alert");
    summary_live_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h80 && statusSecond == 8'h00 && !maskFirst_r[7])
        |=> !alertOutN)
        else $error("unmasked first summary missed");
    any_live_a : assert property (@(posedge mclk) disable iff (!resetn)
        ((statusFirst & ~maskFirst_r) != 8'h00)
        |=> !alertOutN)
        else $error("unmasked condition left alert released");

    // ----------------------------------------------------------------
    // checks: second group
    // ----------------------------------------------------------------
    summary_second_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h00 && statusSecond == 8'h02 && maskSecond_r[1])
        |=> alertOutN)
        else $error("masked second summary raised alert");
    summary_second_live_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h00 && statusSecond == 8'h02 && !maskSecond_r[1])
        |=> !alertOutN)
        else $error("unmasked second summary missed");
    twelve_masked_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h00 && statusSecond == 8'h01 && twelveVoltMode && maskSecond_r[0])
        |=> alertOutN)
        else $error("masked twelve-volt event raised alert");
    twelve_live_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h00 && statusSecond == 8'h01 && twelveVoltMode && !maskSecond_r[0])
        |=> !alertOutN)
        else $error("unmasked twelve-volt event missed");
    fan_masked_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h00 && statusSecond[1:0] == 2'h0 && statusSecond[7:5] == 3'h0
            && (statusSecond[4:2] & ~maskSecond_r[4:2]) == 3'h0) |=> alertOutN)
        else $error("masked fan fault raised alert");
    fan_timer_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h00 && statusSecond == 8'h20 && maskSecond_r[5])
        |=> alertOutN)
        else $error("masked fan four or timer event raised alert");
    fan_timer_live_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h00 && statusSecond == 8'h20 && !maskSecond_r[5])
        |=> !alertOutN)
        else $error("unmasked fan four or timer event missed");
    diode_masked_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h00 && statusSecond[5:0] == 6'h00
            && (statusSecond[7:6] & ~maskSecond_r[7:6]) == 2'h0) |=> alertOutN)
        else $error("masked diode fault raised alert");
    diode_live_a : assert property (@(posedge mclk) disable iff (!resetn)
        (statusFirst == 8'h00 && statusSecond == 8'h40 && !maskSecond_r[6])
        |=> !alertOutN)
        else $error("unmasked diode fault missed");

    // ----------------------------------------------------------------
    // checks: registers and freeze
    // ----------------------------------------------------------------
    reset_values_a : assert property (@(posedge mclk)
        !resetn |=> (resetn || (maskFirst_r == amer_pkg::MASK_FIRST_RST
            && maskSecond_r == amer_pkg::MASK_SECOND_RST && alertOutN
            && extVolt == amer_pkg::EXT_RST && extMixed == amer_pkg::EXT_RST)))
        else $error("reset left a register set or the alert driven");
    mask_first_wr_a : assert property (@(posedge mclk) disable iff (!resetn)
        (regWrite && selMaskFirst)
        |=> maskFirst_r == $past(regWdata))
        else $error("first mask write did not land");
    mask_second_wr_a : assert property (@(posedge mclk) disable iff (!resetn)
        (regWrite && selMaskSecond)
        |=> maskSecond_r == $past(regWdata))
        else $error("second mask write did not land");
    mask_first_view_a : assert property (@(posedge mclk) disable iff (!resetn)
        selMaskFirst
        |-> regRdata == maskFirst_r)
        else $error("first mask read wrong");
    mask_second_view_a : assert property (@(posedge mclk) disable iff (!resetn)
        selMaskSecond
        |-> regRdata == maskSecond_r)
        else $error("second mask read wrong");
    ext_volt_view_a : assert property (@(posedge mclk) disable iff (!resetn)
        selExtVolt
        |-> regRdata == {result_r[3][1:0], result_r[2][1:0], result_r[1][1:0], result_r[0][1:0]})
        else $error("voltage low bits read wrong");
    ext_mixed_view_a : assert property (@(posedge mclk) disable iff (!resetn)
        selExtMixed
        |-> regRdata == {result_r[7][1:0], result_r[6][1:0], result_r[5][1:0], result_r[4][1:0]})
        else $error("mixed low bits read wrong");
    mixed_freeze_a : assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && selExtMixed)
        |=> msbPending_r[7:4] == 4'hF)
        else $error("ext read did not freeze mixed results");
    same_cycle_a : assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && selExtVolt)
        |=> $stable(result_r[0]))
        else $error("result changed in the ext read cycle");
    upper_release_a : assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && regAddr == amer_pkg::MSB_BASE_ADDR)
        |=> !msbPending_r[0])
        else $error("upper read did not release channel zero");
    mixed_release_a : assert property (@(posedge mclk) disable iff (!resetn)
        (regRead && regAddr == amer_pkg::MSB_BASE_ADDR + 8'h07)
        |=> !msbPending_r[7])
        else $error("upper read did not release channel seven");
    hold_mixed_a : assert property (@(posedge mclk) disable iff (!resetn)
        msbPending_r[7]
        |=> $stable(result_r[7]))
        else $error("frozen mixed result changed");
    upper_view_a : assert property (@(posedge mclk) disable iff (!resetn)
        (selMsb && msbOffset == 8'h00)
        |-> regRdata == result_r[0][RW-1:2])
        else $error("upper byte read wrong");
endmodule : amer_alert_mask

// file: shared/amer_pkg.sv
// register map, field positions and reset values for alert masking and extended resolution
package amer_pkg;
    localparam logic [7:0] MASK_FIRST_ADDR  = 8'h74;
    localparam logic [7:0] MASK_SECOND_ADDR = 8'h75;
    localparam logic [7:0] EXT_VOLT_ADDR    = 8'h76;
    localparam logic [7:0] EXT_MIXED_ADDR   = 8'h77;
    localparam logic [7:0] MASK_FIRST_RST   = 8'h00;
    localparam logic [7:0] MASK_SECOND_RST  = 8'h00;
    localparam logic [7:0] EXT_RST          = 8'h00;
    localparam logic [7:0] MSB_RST          = 8'h00;
    // status/mask bit positions, channel count and result width
    localparam int SUMMARY_BIT_FIRST  = 7;
    localparam int SUMMARY_BIT_SECOND = 1;
    localparam int TWELVE_VOLT_BIT    = 0;
    localparam int FAN4_TIMER_BIT     = 5;
    localparam int NUM_CHAN           = 8;
    localparam int RES_WIDTH          = 10;
    // upper-result registers start here, one per channel in ext-register field order
    localparam logic [7:0] MSB_BASE_ADDR = 8'h20;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage : amer_pkg
